// File: core/cfgdec_top.sv
// Configuration word decoder with start-up sequencing and APB access
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Options come from word at 2007h
// - Config space reachable only in programming mode
// - Programmed bit reads 0, unprogrammed 1
// - Bits 15 and 14 always read 1
// - Bit 13 low enables debugger, owns pins
// - Bit 12 high enables low-voltage programming
// - Bit 11 high enables clock monitor
// - Bit 10 high enables oscillator switchover
// - Bits 9-8 select brown-out reset mode
// - Power-up timer holds reset 64 ms
// - Brown-out resets, stretched by power-up timer
// - Oscillator timer holds reset until stable
// - Sleep ends on reset, watchdog, interrupt
// - Brown-out enable leaves power-up timer alone
// - Bit 4 low enables power-up timer
// - Bit 3 or software bit enables watchdog
module cfgdec_top
#(
  parameter int unsigned POWER_UP_TIMER_CYCLES = cfgdec_pkg::POWER_UP_TIMER_CYCLES  // Power-up delay cycles
)
(
  input  wire logic                          i_clk,              // 10 MHz system clock
  input  wire logic                          i_reset_n,          // Power-on reset, async
  input  wire logic                          i_psel,             // APB select
  input  wire logic                          i_penable,          // APB enable
  input  wire logic                          i_pwrite,           // APB direction
  input  wire logic [cfgdec_pkg::ADDR_W-1:0] i_paddr,            // APB byte address
  input  wire logic [cfgdec_pkg::DATA_W-1:0] i_pwdata,           // APB write data
  output var  logic [cfgdec_pkg::DATA_W-1:0] o_prdata,           // APB read data
  output var  logic                          o_pready,           // APB ready
  output var  logic                          o_pslverr,          // APB error
  input  wire logic                          i_prog_mode,        // Programming entry pin
  input  wire logic                          i_ext_reset,        // Master clear pin, high
  input  wire logic                          i_brownout_detect,  // Supply below threshold
  input  wire logic                          i_osc_stable,       // Crystal running
  input  wire logic                          i_sleep_enter,      // Core sleep request
  input  wire logic                          i_wdt_wake,         // Watchdog wake event
  input  wire logic                          i_irq_pending,      // Interrupt wake event
  output var  logic                          o_device_reset,     // Hold core in reset
  output var  logic                          o_sleeping,         // Core in sleep
  output var  logic                          o_debug_enable,     // Debugger on
  output var  logic                          o_debug_pins_gpio,  // Debug pins are I/O
  output var  logic                          o_low_voltage_prog_enable, // Programming pin live
  output var  logic                          o_prog_needs_hv,    // Master clear HV needed
  output var  logic                          o_clock_monitor_enable,    // Clock monitor on
  output var  logic                          o_osc_switchover_enable,   // Switchover on
  output var  logic                          o_brownout_reset_active,   // Brown-out armed
  output var  logic                          o_power_up_timer_enable,   // Delay enabled
  output var  logic                          o_watchdog_enable   // Watchdog running
);
  import cfgdec_pkg::*;

  // Reset release and pin synchronisers
  logic [1:0]    rst_q;                 // Reset release chain
  logic          rst_n;                 // Synchronised reset
  logic [3:0]    pin_meta;              // First stage, read only by second
  logic [3:0]    pin_sync;              // Second stage
  logic          prog_s;                // Programming mode
  logic          ext_s;                 // External reset
  logic          brown_s;               // Brown-out detect
  logic          osc_s;                 // Oscillator stable

  // Sequencer and latched option state
  cfgdec_state_t state;                 // Start-up state
  logic [CFG_W-1:0] cfg_word;           // Latched configuration word
  logic          stretch;               // Next start may use power-up delay
  logic          sleeping;              // Core sleeping
  logic          sw_bor;                // Software brown-out enable
  logic          sw_wdt;                // Software watchdog enable
  logic          bor_active;            // Brown-out reset armed
  cfgdec_bor_t   bor_sel;               // Brown-out selection field

  // Bus decode
  logic [13:0]   idx;                   // Word index of the access
  logic          access_ph;             // Access phase
  logic          xfer_done;             // Edge where the master completes
  logic          hit_status;
  logic          hit_ctrl;
  logic          in_space;              // Configuration space index
  logic          in_mem;                // Index held in the store
  logic          bad_access;            // Answer with an error
  logic [DATA_W-1:0] next_rdata;        // Read data for this access

  cfgdec_mem_if  mem_if ();
  cfgdec_tmr_if  power_up_timer_if ();
  cfgdec_tmr_if  ost_if ();

  // Reset release through two flip-flops
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      rst_q <= 2'h0;
    end
    else
    begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  // Two-stage pin synchronisers
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_meta <= 4'h0;
      pin_sync <= 4'h0;
    end
    else
    begin
      pin_meta <= {i_prog_mode, i_ext_reset, i_brownout_detect, i_osc_stable};
      pin_sync <= pin_meta;
    end
  end
  assign {prog_s, ext_s, brown_s, osc_s} = pin_sync;

  // Store and timers
  cfgdec_mem u_mem (
    .i_clk   (i_clk),
    .i_rst_n (rst_n),
    .mem     (mem_if)
  );

  cfgdec_timer #(.COUNT(POWER_UP_TIMER_CYCLES)) u_power_up_timer (
    .i_clk   (i_clk),
    .i_rst_n (rst_n),
    .tmr     (power_up_timer_if)
  );

  cfgdec_timer #(.COUNT(OST_CYCLES)) u_ost (
    .i_clk   (i_clk),
    .i_rst_n (rst_n),
    .tmr     (ost_if)
  );

  // Loader reads the word; programmer owns the store in programming mode
  assign mem_if.addr  = prog_s ? idx[MEM_AW-1:0] : CFG_WORD_IDX[MEM_AW-1:0];
  assign mem_if.wdata = i_pwdata[CELL_W-1:0];
  assign mem_if.we    = xfer_done & i_pwrite & in_mem & prog_s;
  assign power_up_timer_if.run  = (state == ST_POWER_UP_TIMER);
  assign ost_if.run   = (state == ST_OST) & osc_s;

  // Brown-out arming per selection field
  assign bor_sel = cfgdec_bor_t'(cfg_word[CFG_BOR_HI:CFG_BOR_LO]);
  always_comb
  begin
    unique case (bor_sel)
      BOR_ALWAYS:   bor_active = 1'b1;
      BOR_RUN_ONLY: bor_active = ~sleeping;
      BOR_SOFT:     bor_active = sw_bor;
      BOR_OFF:      bor_active = 1'b0;
    endcase
  end

  // Start-up sequencer
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state    <= ST_LOAD;
      stretch  <= 1'b1;                       // Power-up start
      cfg_word <= {CFG_UNIMPL, CELL_ERASED};
    end
    else if ((prog_s || ext_s) && state != ST_BOR)
    begin
      state <= ST_LOAD;                       // Hold in reset, reload after
    end
    else if (brown_s && bor_active && state inside {ST_POWER_UP_TIMER, ST_OST, ST_RUN})
    begin
      state   <= ST_BOR;
      stretch <= 1'b1;
    end
    else
    begin
      unique case (state)
        ST_LOAD:  state <= ST_LATCH;          // Read issued this cycle
        ST_LATCH:
        begin
          cfg_word <= {CFG_UNIMPL, mem_if.rdata};
          stretch  <= 1'b0;
          // Delay only on power-up or brown-out, and only if enabled
          if (stretch && !mem_if.rdata[CFG_POWER_UP_TIMER_ENABLE])
          begin
            state <= ST_POWER_UP_TIMER;
          end
          else
          begin
            state <= ST_OST;
          end
        end
        ST_POWER_UP_TIMER:
        begin
          if (power_up_timer_if.done)
          begin
            state <= ST_OST;
          end
        end
        ST_OST:
        begin
          if (ost_if.done)
          begin
            state <= ST_RUN;
          end
        end
        ST_RUN:   state <= ST_RUN;
        ST_BOR:
        begin
          if (!brown_s)
          begin
            state <= ST_LOAD;
          end
        end
      endcase
    end
  end

  // Sleep entry and wake causes
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sleeping <= 1'b0;
    end
    else if (state != ST_RUN)
    begin
      sleeping <= 1'b0;                       // any reset: external, brown-out or programming
    end
    else if (i_wdt_wake || i_irq_pending)
    begin
      sleeping <= 1'b0;
    end
    else if (i_sleep_enter)
    begin
      sleeping <= 1'b1;
    end
  end

  // Software enables, cleared each time the sequencer passes through ST_LOAD
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sw_bor <= 1'b0;
      sw_wdt <= 1'b0;
    end
    else if (state == ST_LOAD)
    begin
      sw_bor <= 1'b0;
      sw_wdt <= 1'b0;
    end
    else if (xfer_done && i_pwrite && hit_ctrl)
    begin
      sw_bor <= i_pwdata[CTRL_SBOR];
      sw_wdt <= i_pwdata[CTRL_SWDT];
    end
  end

  // Bus decode
  assign idx        = i_paddr[ADDR_W-1:2];
  assign access_ph  = i_psel & i_penable;
  assign xfer_done  = access_ph & o_pready;
  assign hit_status = (i_paddr == STATUS_ADDR);
  assign hit_ctrl   = (i_paddr == CONTROL_ADDR);
  assign in_space   = idx[CFG_SPACE_BIT];
  assign in_mem     = in_space && (idx[13:MEM_AW] == CFG_MEM_TAG);
  // Config space refused outside programming mode; status is read-only
  assign bad_access = ~(hit_status | hit_ctrl | in_space)
                    | (in_space & ~prog_s)
                    | (hit_status & i_pwrite);

  // Read data selection
  always_comb
  begin
    next_rdata = '0;
    if (bad_access)
    begin
      next_rdata = '0;
    end
    else if (hit_status)
    begin
      next_rdata[STAT_RUN]                 = (state == ST_RUN);
      next_rdata[STAT_SLEEP]               = sleeping;
      next_rdata[STAT_BOR]                 = bor_active;
      next_rdata[STAT_WDT]                 = o_watchdog_enable;
      next_rdata[STAT_PROG]                = prog_s;
      next_rdata[STAT_WORD +: CFG_W]       = cfg_word;
    end
    else if (hit_ctrl)
    begin
      next_rdata[CTRL_SBOR] = sw_bor;
      next_rdata[CTRL_SWDT] = sw_wdt;
    end
    else if (in_mem)
    begin
      next_rdata[CFG_W-1:0] = {CFG_UNIMPL, mem_if.rdata};
    end
    else
    begin
      next_rdata[CFG_W-1:0] = {CFG_UNIMPL, CELL_ERASED};
    end
  end

  // APB answer: ready one cycle into the access phase
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= '0;
    end
    else if (access_ph && !o_pready)
    begin
      o_pready  <= 1'b1;
      o_pslverr <= bad_access;
      o_prdata  <= i_pwrite ? '0 : next_rdata;
    end
    else
    begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end
  end

  // Registered option outputs
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_device_reset            <= 1'b1;
      o_sleeping                <= 1'b0;
      o_debug_enable            <= 1'b0;
      o_debug_pins_gpio         <= 1'b1;
      o_low_voltage_prog_enable <= 1'b0;
      o_prog_needs_hv           <= 1'b1;
      o_clock_monitor_enable    <= 1'b0;
      o_osc_switchover_enable   <= 1'b0;
      o_brownout_reset_active   <= 1'b0;
      o_power_up_timer_enable   <= 1'b0;
      o_watchdog_enable         <= 1'b0;
    end
    else
    begin
      o_device_reset            <= (state != ST_RUN);
      o_sleeping                <= sleeping;
      o_debug_enable            <= ~cfg_word[CFG_DEBUG];
      o_debug_pins_gpio         <= cfg_word[CFG_DEBUG];
      o_low_voltage_prog_enable <= cfg_word[CFG_LVP];
      o_prog_needs_hv           <= ~cfg_word[CFG_LVP];
      o_clock_monitor_enable    <= cfg_word[CFG_FCM];
      o_osc_switchover_enable   <= cfg_word[CFG_OSC_SWITCHOVER_ENABLE];
      o_brownout_reset_active   <= bor_active;
      o_power_up_timer_enable   <= ~cfg_word[CFG_POWER_UP_TIMER_ENABLE];
      o_watchdog_enable         <= cfg_word[CFG_WATCHDOG_ENABLE] | sw_wdt;
    end
  end

endmodule

`default_nettype wire

// File: core/cfgdec_pkg.sv
// Shared constants and types for the configuration word decoder
package cfgdec_pkg;

  // Clock and start-up delay figures
  localparam int unsigned CLK_HZ       = 10_000_000;             // System clock rate
  localparam int unsigned POWER_UP_TIMER_TIME_MS = 64;                     // Power-up delay, nominal
  localparam int unsigned POWER_UP_TIMER_CYCLES  = POWER_UP_TIMER_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned OST_CYCLES   = 1024;                   // Oscillator settle count

  // Bus and storage widths
  localparam int unsigned ADDR_W    = 16;                        // APB byte address width
  localparam int unsigned DATA_W    = 32;                        // APB data width
  localparam int unsigned CFG_W     = 16;                        // Configuration word width
  localparam int unsigned CELL_W    = 14;                        // Implemented cell bits
  localparam int unsigned MEM_AW    = 3;                         // Stored word index width
  localparam int unsigned MEM_WORDS = 8;                         // Words kept in the store

  // Register indices and byte addresses
  localparam logic [13:0] CFG_WORD_IDX = 14'h2007;               // Configuration word index
  localparam logic [10:0] CFG_MEM_TAG  = 11'h400;                // Index bits 13:3 of store
  localparam int unsigned CFG_SPACE_BIT = 13;                    // Set for 2000h-3fffh
  localparam logic [15:0] STATUS_ADDR  = 16'h0000;               // Decoder status
  localparam logic [15:0] CONTROL_ADDR = 16'h0004;               // Software enables

  // Configuration word fields
  localparam logic [CELL_W-1:0] CELL_ERASED = 14'h3fff;          // Unprogrammed cells
  localparam logic [1:0]  CFG_UNIMPL  = 2'h3;                    // Bits 15:14 value
  localparam int unsigned CFG_DEBUG   = 13;
  localparam int unsigned CFG_LVP     = 12;
  localparam int unsigned CFG_FCM     = 11;
  localparam int unsigned CFG_OSC_SWITCHOVER_ENABLE    = 10;
  localparam int unsigned CFG_BOR_HI  = 9;
  localparam int unsigned CFG_BOR_LO  = 8;
  localparam int unsigned CFG_POWER_UP_TIMER_ENABLE   = 4;
  localparam int unsigned CFG_WATCHDOG_ENABLE    = 3;

  // Control and status fields
  localparam int unsigned CTRL_SBOR   = 0;
  localparam int unsigned CTRL_SWDT   = 1;
  localparam int unsigned STAT_RUN    = 0;
  localparam int unsigned STAT_SLEEP  = 1;
  localparam int unsigned STAT_BOR    = 2;
  localparam int unsigned STAT_WDT    = 3;
  localparam int unsigned STAT_PROG   = 4;
  localparam int unsigned STAT_WORD   = 16;

  // Brown-out selection codes
  typedef enum logic [1:0] {
    BOR_OFF      = 2'b00,
    BOR_SOFT     = 2'b01,
    BOR_RUN_ONLY = 2'b10,
    BOR_ALWAYS   = 2'b11
  } cfgdec_bor_t;

  // Start-up sequence states
  typedef enum logic [2:0] {
    ST_LOAD, ST_LATCH, ST_POWER_UP_TIMER, ST_OST, ST_RUN, ST_BOR
  } cfgdec_state_t;

endpackage

// File: core/cfgdec_if.sv
// Carriers between the decoder and its store and timers
`timescale 1ns/1ps
`default_nettype none

// Configuration store port
interface cfgdec_mem_if;
  logic [cfgdec_pkg::MEM_AW-1:0] addr;   // Word index
  logic [cfgdec_pkg::CELL_W-1:0] wdata;  // Cells to program
  logic                          we;     // Program strobe
  logic [cfgdec_pkg::CELL_W-1:0] rdata;  // Registered read data
  modport owner (output addr, wdata, we, input rdata);
  modport store (input addr, wdata, we, output rdata);
endinterface

// Delay timer port
interface cfgdec_tmr_if;
  logic run;   // Count while high, clear when low
  logic done;  // Delay elapsed
  modport ctrl (output run, input done);
  modport tmr  (input run, output done);
endinterface

`default_nettype wire

// File: core/cfgdec_mem.sv
// Configuration cell store, set back to erased by reset, with registered read
`timescale 1ns/1ps
`default_nettype none

module cfgdec_mem
  import cfgdec_pkg::*;
(
  input wire logic         i_clk,     // System clock
  input wire logic         i_rst_n,   // Synchronised reset, active low
  cfgdec_mem_if.store      mem        // Store port
);

  logic [CELL_W-1:0] cells [MEM_WORDS];  // Stored words

  // Cells start erased and take programmed values
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      for (int i = 0; i < MEM_WORDS; i++)
      begin
        cells[i] <= CELL_ERASED;
      end
    end
    else if (mem.we)
    begin
      cells[mem.addr] <= mem.wdata;
    end
  end

  // Read data from a register
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      mem.rdata <= CELL_ERASED;
    end
    else
    begin
      mem.rdata <= cells[mem.addr];
    end
  end

endmodule

`default_nettype wire

// File: core/cfgdec_timer.sv
// Start-up delay counter, restarts whenever its run level drops
`timescale 1ns/1ps
`default_nettype none

module cfgdec_timer
#(
  parameter int unsigned COUNT = 1            // Cycles of run before done
)
(
  input wire logic         i_clk,             // System clock
  input wire logic         i_rst_n,           // Synchronised reset, active low
  cfgdec_tmr_if.tmr        tmr                // Run and done
);

  localparam int unsigned W = $clog2(COUNT + 1);
  logic [W-1:0] cnt;                           // Cycles counted so far

  // Count run cycles, done after COUNT of them
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cnt      <= '0;
      tmr.done <= 1'b0;
    end
    else if (!tmr.run)
    begin
      cnt      <= '0;
      tmr.done <= 1'b0;
    end
    else if (!tmr.done)
    begin
      cnt      <= cnt + 1'b1;
      tmr.done <= (cnt == W'(COUNT - 1));
    end
  end

endmodule

`default_nettype wire

// File: bench/cfgdec_chk.sv
// Port-level assertions for the configuration word decoder
`timescale 1ns/1ps
`default_nettype none
module cfgdec_chk
#(
  parameter int unsigned POWER_UP_TIMER_CYCLES = 20  // Power-up delay cycles
)
(
  input wire logic        i_clk,
  input wire logic        i_reset_n,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic [15:0] i_paddr,
  input wire logic        i_prog_mode,
  input wire logic        i_sleep_enter,
  input wire logic        i_wdt_wake,
  input wire logic        i_irq_pending,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire logic        o_device_reset,
  input wire logic        o_sleeping,
  input wire logic        o_debug_enable,
  input wire logic        o_debug_pins_gpio,
  input wire logic        o_low_voltage_prog_enable,
  input wire logic        o_prog_needs_hv
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);

  // Access phase still waiting for its answer
  sequence s_taken;
    i_psel && i_penable && !o_pready;
  endsequence

  // Config space access long after programming mode ended
  sequence s_locked;
    s_taken ##0 (i_paddr[15] && !i_prog_mode && !$past(i_prog_mode, 4));
  endsequence

  a_answer_next: assert property (s_taken |=> o_pready)
    else $error("no answer one cycle after access");
  a_ready_pulse: assert property (o_pready |=> !o_pready)
    else $error("ready stood longer than one cycle");
  a_err_with_ready: assert property (o_pslverr |-> o_pready)
    else $error("error without ready");
  a_cfg_locked: assert property (s_locked |=> o_pslverr && o_prdata == 32'h0)
    else $error("config space reached outside programming");
  a_debug_pins: assert property (o_debug_enable != o_debug_pins_gpio)
    else $error("debugger and pin use disagree");
  a_lvp_pin: assert property (o_low_voltage_prog_enable != o_prog_needs_hv)
    else $error("low voltage and high voltage both or neither");
  a_reset_hold: assert property ($rose(i_reset_n) |-> o_device_reset [*8])
    else $error("core released too early");
  a_opts_hold: assert property (!o_device_reset && !$past(o_device_reset)
    |-> $stable(o_debug_enable) && $stable(o_low_voltage_prog_enable))
    else $error("option changed while running");
  a_sleep_enter: assert property (i_sleep_enter && !o_device_reset && !o_sleeping
    && !i_irq_pending && !i_wdt_wake |-> ##[1:2] o_sleeping)
    else $error("sleep not entered");
  a_sleep_wake: assert property (o_sleeping && (i_irq_pending || i_wdt_wake)
    |-> ##[1:2] !o_sleeping)
    else $error("wake cause ignored");
endmodule

bind cfgdec_top cfgdec_chk #(.POWER_UP_TIMER_CYCLES(POWER_UP_TIMER_CYCLES)) cfgdec_chk_inst (
  .i_clk(i_clk), .i_reset_n(i_reset_n), .i_psel(i_psel), .i_penable(i_penable),
  .i_paddr(i_paddr), .i_prog_mode(i_prog_mode), .i_sleep_enter(i_sleep_enter),
  .i_wdt_wake(i_wdt_wake), .i_irq_pending(i_irq_pending), .o_prdata(o_prdata),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .o_device_reset(o_device_reset),
  .o_sleeping(o_sleeping), .o_debug_enable(o_debug_enable),
  .o_debug_pins_gpio(o_debug_pins_gpio),
  .o_low_voltage_prog_enable(o_low_voltage_prog_enable),
  .o_prog_needs_hv(o_prog_needs_hv)
);
`default_nettype wire

// File: bench/cfgdec_top_tb.sv
// Self-checking bench for the configuration word decoder
`timescale 1ns/1ps
`default_nettype none
module cfgdec_top_tb;
  import cfgdec_pkg::*;
  localparam int unsigned POWER_UP_TIMER  = 20;          // Shortened power-up delay
  localparam logic [15:0] CADDR = 16'h801c;    // Byte address of word 2007h
  localparam logic [13:0] CELLS [4] = '{14'h3fff, 14'h09e7, 14'h26f7, 14'h10ef};
  logic        clk    = 1'b0;                  // System clock
  logic        rst_n  = 1'b0;                  // Power-on reset
  logic        psel   = 1'b0;                  // Bus select
  logic        pen    = 1'b0;                  // Bus enable
  logic        pwr    = 1'b0;                  // Bus direction
  logic [15:0] paddr  = 16'h0000;              // Bus address
  logic [31:0] pwdata = 32'h0;                 // Bus write data
  logic        prog   = 1'b0;                  // Programming mode pin
  logic        bod    = 1'b0;                  // Supply low
  logic        slp    = 1'b0;                  // Sleep request
  logic        wwake  = 1'b0;                  // Watchdog wake
  logic        irq    = 1'b0;                  // Interrupt wake
  logic        osc    = 1'b0;                  // Crystal stable
  logic        master_clear_pin   = 1'b0;                  // External reset pin
  logic [31:0] rd;                             // Last read data
  logic        err;                            // Last error flag
  int          fail_count = 0;                 // Mismatches
  int          compares = 0;                   // Comparisons
  wire logic [31:0] prdata;                    // Read data
  wire logic        pready;                    // Bus answer
  wire logic        pslverr;                   // Bus refusal
  wire logic        dev_rst;                   // Core held
  wire logic        sleeping;                  // Core asleep
  wire logic [8:0]  opts;                      // Decoded options

  cfgdec_top #(.POWER_UP_TIMER_CYCLES(POWER_UP_TIMER)) cfgdec_top_inst (
    .i_clk(clk), .i_reset_n(rst_n), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_prog_mode(prog), .i_ext_reset(master_clear_pin),
    .i_brownout_detect(bod), .i_osc_stable(osc), .i_sleep_enter(slp),
    .i_wdt_wake(wwake), .i_irq_pending(irq), .o_device_reset(dev_rst),
    .o_sleeping(sleeping), .o_debug_enable(opts[8]), .o_debug_pins_gpio(opts[7]),
    .o_low_voltage_prog_enable(opts[6]), .o_prog_needs_hv(opts[5]),
    .o_clock_monitor_enable(opts[4]), .o_osc_switchover_enable(opts[3]),
    .o_brownout_reset_active(opts[2]), .o_power_up_timer_enable(opts[1]),
    .o_watchdog_enable(opts[0])
  );

  // Free-running clock, 100 ns period
  always #50 clk = ~clk;

  // Verdict and end of run
  task automatic stop_test();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Abort on a hang
  task automatic bail(input string msg);
    fail_count++;
    $display("unexpected at %0t: %s", $time, msg);
    stop_test();
  endtask

  // Compare one result word
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // One bus transfer; result left in rd and err
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 10);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (n >= 10)
      bail("no bus answer");
  endtask

  // Count cycles until the core leaves reset
  task automatic wait_run(output int n);
    n = 0;
    while (dev_rst !== 1'b0 && n < 5000)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 5000)
      bail("core never ran");
  endtask

  // Expected option outputs for a word, software bits and sleep
  function automatic logic [31:0] exp_opts(input logic [15:0] w, input logic sw,
                                           input logic sl);
    logic bor;
    case (w[9:8])
      2'b11:   bor = 1'b1;
      2'b10:   bor = ~sl;
      2'b01:   bor = sw;
      default: bor = 1'b0;
    endcase
    return {23'h0, ~w[13], w[13], w[12], ~w[12], w[11], w[10], bor, ~w[4], w[3] | sw};
  endfunction

  // Main sequence
  initial
  begin
    int          n;
    logic [15:0] w;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (40) @(posedge clk);
    chk({31'h0, dev_rst}, 32'h1);
    osc <= 1'b1;
    wait_run(n);
    chk({31'h0, n >= 1024 && n <= 1036}, 32'h1);
    apb(1'b1, STATUS_ADDR, 32'hffffffff);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, 16'h0010, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("test refusals done");
    for (int i = 0; i < 4; i++)
    begin
      w = {2'b11, CELLS[i]};
      prog <= 1'b1;
      repeat (5) @(posedge clk);
      apb(1'b1, CADDR, {18'h0, CELLS[i]});
      apb(1'b0, CADDR, 32'h0);
      chk(rd, {16'h0, w});
      prog <= 1'b0;
      wait_run(n);
      apb(1'b0, CADDR, 32'h0);
      chk({err, rd[30:0]}, 32'h80000000);
      apb(1'b0, STATUS_ADDR, 32'h0);
      chk({16'h0, rd[31:16]}, {16'h0, w});
      chk({23'h0, opts}, exp_opts(w, 1'b0, 1'b0));
      apb(1'b1, CONTROL_ADDR, 32'h3);
      apb(1'b0, CONTROL_ADDR, 32'h0);
      chk(rd, 32'h3);
      repeat (2) @(posedge clk);
      chk({23'h0, opts}, exp_opts(w, 1'b1, 1'b0));
      slp <= 1'b1;
      @(posedge clk);
      slp <= 1'b0;
      repeat (3) @(posedge clk);
      chk({31'h0, sleeping}, 32'h1);
      chk({23'h0, opts}, exp_opts(w, 1'b1, 1'b1));
      if (i % 2 == 1)
        wwake <= 1'b1;
      else
        irq <= 1'b1;
      @(posedge clk);
      wwake <= 1'b0;
      irq <= 1'b0;
      repeat (3) @(posedge clk);
      chk({31'h0, sleeping}, 32'h0);
      if (i < 3)
      begin
        bod <= 1'b1;
        repeat (5) @(posedge clk);
        chk({31'h0, dev_rst}, 32'h1);
        bod <= 1'b0;
        wait_run(n);
        n = n - 1024 - (w[4] ? 0 : POWER_UP_TIMER);
        chk({31'h0, n >= 0 && n <= 12}, 32'h1);
      end
      $display("test word %0d done", i);
    end
    slp <= 1'b1;
    @(posedge clk);
    slp <= 1'b0;
    repeat (3) @(posedge clk);
    master_clear_pin <= 1'b1;
    repeat (6) @(posedge clk);
    chk({30'h0, dev_rst, sleeping}, 32'h2);
    master_clear_pin <= 1'b0;
    wait_run(n);
    chk({31'h0, n >= 1024 && n <= 1036}, 32'h1);
    $display("test external reset done");
    stop_test();
  end
endmodule
`default_nettype wire
